// ===== core/wwdt_pkg.sv
// Package of constants and helpers for the windowed watchdog timer
package wwdt_pkg;
   // ==========================================================
   // Register indices (byte address is four times the index)
   localparam logic [1:0] WWDT_IDX_CTRL   = 2'h0;
   localparam logic [1:0] WWDT_IDX_STATUS = 2'h1;
   localparam logic [1:0] WWDT_IDX_UNLOCK = 2'h2;
   localparam int         WWDT_ADDR_W     = 4;

   // ==========================================================
   // Field positions
   localparam int WWDT_PERIOD_LSB = 0;
   localparam int WWDT_WINDOW_LSB = 4;
   localparam int WWDT_LOCK_BIT   = 7;
   localparam int WWDT_BUSY_BIT   = 0;

   // ==========================================================
   // Reset values and codes
   localparam logic [7:0]  WWDT_CTRL_RST   = 8'h00;
   localparam logic [3:0]  WWDT_CODE_OFF   = 4'h0;
   localparam logic [3:0]  WWDT_CODE_MAX   = 4'hb;
   localparam logic [13:0] WWDT_LEN_MIN    = 14'h0008;
   localparam logic [13:0] WWDT_LEN_MAX    = 14'h2000;
   localparam int          WWDT_CNT_W      = 14;
   localparam logic [1:0]  WWDT_SYNC_TICKS = 2'h3;   // Two to three periods
   localparam logic [1:0]  WWDT_RESP_OKAY  = 2'h0;
   localparam logic [1:0]  WWDT_RESP_DEC   = 2'h3;

   // ==========================================================
   // Timing: tick rate in Hz and unlock window in CPU cycles
   localparam int         WWDT_TICK_HZ    = 1024;
   localparam logic [2:0] WWDT_UNLOCK_CYC = 3'h4;

   // Length in ticks of a period or window code; reserved -> longest
   function automatic logic [13:0] wwdt_len(input logic [3:0] code);
      if (code == WWDT_CODE_OFF || code > WWDT_CODE_MAX) begin
         wwdt_len = WWDT_LEN_MAX;
      end else begin
         wwdt_len = WWDT_LEN_MIN << (code - 4'h1);
      end
   endfunction
endpackage

// ===== core/wwdt_sync_if.sv
// Interface between watchdog core and its tick synchroniser
`timescale 1ns/1ps
interface wwdt_sync_if;
   logic tick_en;
   logic ctrl_req;
   logic ctrl_done;
   logic wdr_req;
   logic wdr_done;
   modport core (input tick_en, input ctrl_done, input wdr_done,
                 output ctrl_req, output wdr_req);
   modport sync (output tick_en, output ctrl_done, output wdr_done,
                 input ctrl_req, input wdr_req);
endinterface

// ===== core/wwdt_tick_sync.sv
// Tick edge detector and tick-counted transfer of control and restart
`timescale 1ns/1ps
module wwdt_tick_sync
   import wwdt_pkg::*;
(
   // Clock and reset
   input  wire logic   aclk,
   input  wire logic   aresetn,
   // Tick from the low-power oscillator
   input  wire logic   watchdog_tick_clock,
   // Core side
   wwdt_sync_if.sync   sif
);
   logic       tick_meta;
   logic       tick_sync;
   logic       tick_prev;
   logic       ctrl_pend;
   logic [1:0] ctrl_cnt;
   logic       wdr_pend;
   logic [1:0] wdr_cnt;
   logic       ctrl_done_reg;
   logic       wdr_done_reg;

   // ==========================================================
   // Tick synchroniser and rising edge enable
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick_meta <= 1'b0;
         tick_sync <= 1'b0;
         tick_prev <= 1'b0;
      end else begin
         tick_meta <= watchdog_tick_clock;
         tick_sync <= tick_meta;
         tick_prev <= tick_sync;
      end
   end
   assign sif.tick_en = tick_sync & ~tick_prev;

   // Control transfer: done after the set count of tick edges
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_pend     <= 1'b0;
         ctrl_cnt      <= 2'h0;
         ctrl_done_reg <= 1'b0;
      end else begin
         ctrl_done_reg <= 1'b0;
         if (sif.ctrl_req) begin
            ctrl_pend <= 1'b1;
            ctrl_cnt  <= 2'h0;
         end else if (ctrl_pend && sif.tick_en) begin
            if (ctrl_cnt + 2'h1 == WWDT_SYNC_TICKS) begin
               ctrl_pend     <= 1'b0;
               ctrl_done_reg <= 1'b1;
            end
            ctrl_cnt <= ctrl_cnt + 2'h1;
         end
      end
   end

   // Restart transfer: two to three tick periods
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wdr_pend     <= 1'b0;
         wdr_cnt      <= 2'h0;
         wdr_done_reg <= 1'b0;
      end else begin
         wdr_done_reg <= 1'b0;
         if (sif.wdr_req && !wdr_pend) begin
            wdr_pend <= 1'b1;
            wdr_cnt  <= 2'h0;
         end else if (wdr_pend && sif.tick_en) begin
            if (wdr_cnt + 2'h1 == WWDT_SYNC_TICKS) begin
               wdr_pend     <= 1'b0;
               wdr_done_reg <= 1'b1;
            end
            wdr_cnt <= wdr_cnt + 2'h1;
         end
      end
   end

   assign sif.ctrl_done = ctrl_done_reg;
   assign sif.wdr_done  = wdr_done_reg;
endmodule

// ===== core/wwdt_top.sv
// Windowed watchdog timer with AXI4-Lite register access
//
// Function
// - Nonzero timeout code starts the watchdog
// - Zero closed code Normal, nonzero Window
// - Normal mode: reset request on expiry
// - Restart clears count, new period begins
// - Eleven durations, eight ms to eight s
// - Restart in closed window requests reset
// - Open window follows closed window directly
// - Window mode: reset if open window expires
// - Closed window enforced after first restart
// - Counter advances on independent 1.024 kHz tick
// - Control writes synchronised into tick domain
// - Protected writes need unlock sequence first
// - Control loads from fuses; nonzero period code locks
// - Lock blocks control; clear only debug
// - Keeps counting whenever period code is nonzero, tick source runs and debug halt is low
// - Debug halt stops operation, clears counter
// - After halt, one Normal period first
// - Codes 1..11 give 8..8192 ticks
// - Restart takes two to three ticks
// - Protected write within four cycles of key
`timescale 1ns/1ps
module wwdt_top
   import wwdt_pkg::*;
#(
   parameter logic [7:0] UNLOCK_KEY = 8'ha5   // Arbitrary key value
)(
   // Clock and reset
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   // AXI4-Lite write address
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [WWDT_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]             s_axi_awprot,
   // AXI4-Lite write data
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   // AXI4-Lite write response
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   output logic [1:0]                  s_axi_bresp,
   // AXI4-Lite read address
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   input  wire logic [WWDT_ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]             s_axi_arprot,
   // AXI4-Lite read data
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   // CPU side
   input  wire logic                   watchdog_restart_instr,
   input  wire logic                   debug_halt,
   input  wire logic                   debug_mode,
   // Fuse loader
   input  wire logic [7:0]             watchdog_fuse_config,
   // Oscillator tick
   input  wire logic                   watchdog_tick_clock,
   // Reset controller
   output logic                        sys_reset_req,
   input  wire logic                   sys_reset_ack
);
   wwdt_sync_if sif ();

   logic [7:0]            ctrl_reg;
   logic                  lock_reg;
   logic                  busy_reg;
   logic                  loaded_reg;
   logic [2:0]            unlock_reg;
   logic [3:0]            act_period;
   logic [3:0]            act_window;
   logic [WWDT_CNT_W-1:0] count_reg;
   logic                  closed_reg;
   logic                  armed_reg;
   logic                  rst_req_reg;
   logic                  aw_held;
   logic                  w_held;
   logic [1:0]            aw_idx;
   logic                  aw_bad;
   logic [31:0]           wdata_hold;
   logic [3:0]            wstrb_hold;
   logic                  rvalid_reg;
   logic [31:0]           rdata_reg;
   logic [1:0]            rresp_reg;
   logic                  bvalid_reg;
   logic [1:0]            bresp_reg;
   logic                  do_write;
   logic                  unlocked;
   logic                  wr_ctrl;
   logic                  wr_status;
   logic                  wr_key;
   logic                  wdt_on;
   logic                  win_on;
   logic [WWDT_CNT_W-1:0] count_p1;
   logic                  expire;
   logic                  early;

   // Unmapped or misaligned byte address, shared by both channels
   function automatic logic addr_bad(input logic [WWDT_ADDR_W-1:0] a);
      addr_bad = (a[3:2] > WWDT_IDX_UNLOCK) || (a[1:0] != 2'h0);
   endfunction

   // ==========================================================
   // Tick synchroniser
   wwdt_tick_sync u_sync (
      .aclk                (aclk),
      .aresetn             (aresetn),
      .watchdog_tick_clock (watchdog_tick_clock),
      .sif                 (sif)
   );

   // ==========================================================
   // AXI4-Lite write channel capture
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held    <= 1'b0;
         w_held     <= 1'b0;
         aw_idx     <= 2'h0;
         aw_bad     <= 1'b0;
         wdata_hold <= 32'h0000_0000;
         wstrb_hold <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_idx  <= s_axi_awaddr[3:2];
            aw_bad  <= addr_bad(s_axi_awaddr);
         end else if (do_write) begin
            aw_held <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held     <= 1'b1;
            wdata_hold <= s_axi_wdata;
            wstrb_hold <= s_axi_wstrb;
         end else if (do_write) begin
            w_held <= 1'b0;
         end
      end
   end

   assign s_axi_awready = ~aw_held;
   assign s_axi_wready  = ~w_held;
   assign do_write      = aw_held & w_held & ~bvalid_reg;
   assign unlocked      = (unlock_reg != 3'h0);

   // Decoded accepted writes; low byte lane required
   assign wr_key    = do_write & ~aw_bad & wstrb_hold[0] &
                      (aw_idx == WWDT_IDX_UNLOCK);
   assign wr_ctrl   = do_write & ~aw_bad & wstrb_hold[0] & unlocked &
                      (aw_idx == WWDT_IDX_CTRL) & ~lock_reg &
                      ~busy_reg;
   assign wr_status = do_write & ~aw_bad & wstrb_hold[0] & unlocked &
                      (aw_idx == WWDT_IDX_STATUS);

   // Write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= WWDT_RESP_OKAY;
      end else if (do_write) begin
         bvalid_reg <= 1'b1;
         bresp_reg  <= aw_bad ? WWDT_RESP_DEC : WWDT_RESP_OKAY;
      end else if (s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp  = bresp_reg;

   // ==========================================================
   // AXI4-Lite read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h0000_0000;
         rresp_reg  <= WWDT_RESP_OKAY;
      end else if (s_axi_arvalid && !rvalid_reg) begin
         rvalid_reg <= 1'b1;
         rresp_reg  <= WWDT_RESP_OKAY;
         rdata_reg  <= 32'h0000_0000;
         if (addr_bad(s_axi_araddr)) begin
            rresp_reg <= WWDT_RESP_DEC;
         end else if (s_axi_araddr[3:2] == WWDT_IDX_CTRL) begin
            rdata_reg[7:0] <= ctrl_reg;
         end else if (s_axi_araddr[3:2] == WWDT_IDX_STATUS) begin
            rdata_reg[WWDT_LOCK_BIT] <= lock_reg;
            rdata_reg[WWDT_BUSY_BIT] <= busy_reg;
         end
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end
   assign s_axi_arready = ~rvalid_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rdata   = rdata_reg;
   assign s_axi_rresp   = rresp_reg;

   // ==========================================================
   // Change-protection unlock window, consumed by one write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         unlock_reg <= 3'h0;
      end else if (wr_key && wdata_hold[7:0] == UNLOCK_KEY) begin
         unlock_reg <= WWDT_UNLOCK_CYC;
      end else if (wr_ctrl || wr_status) begin
         unlock_reg <= 3'h0;
      end else if (unlocked) begin
         unlock_reg <= unlock_reg - 3'h1;
      end
   end

   // Control shadow, lock and fuse load at first edge after reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg   <= WWDT_CTRL_RST;
         lock_reg   <= 1'b0;
         loaded_reg <= 1'b0;
      end else if (!loaded_reg) begin
         loaded_reg <= 1'b1;
         ctrl_reg   <= watchdog_fuse_config;
         lock_reg   <= (watchdog_fuse_config[3:0] != WWDT_CODE_OFF);
      end else begin
         if (wr_ctrl) begin
            ctrl_reg <= wdata_hold[7:0];
         end
         if (wr_status && wdata_hold[WWDT_LOCK_BIT]) begin
            lock_reg <= 1'b1;
         end else if (wr_status && debug_mode) begin
            lock_reg <= 1'b0;
         end
      end
   end

   // Sync pending flag; set on write, cleared on transfer done
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         busy_reg <= 1'b0;
      end else if (wr_ctrl) begin
         busy_reg <= 1'b1;
      end else if (sif.ctrl_done) begin
         busy_reg <= 1'b0;
      end
   end
   assign sif.ctrl_req = wr_ctrl;
   assign sif.wdr_req  = watchdog_restart_instr;

   // ==========================================================
   // Settings in force in the tick domain
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         act_period <= WWDT_CODE_OFF;
         act_window <= WWDT_CODE_OFF;
      end else if (!loaded_reg) begin
         act_period <= watchdog_fuse_config[3:0];
         act_window <= watchdog_fuse_config[7:4];
      end else if (sif.ctrl_done) begin
         act_period <= ctrl_reg[WWDT_PERIOD_LSB +: 4];
         act_window <= ctrl_reg[WWDT_WINDOW_LSB +: 4];
      end
   end

   assign wdt_on   = (act_period != WWDT_CODE_OFF);
   assign win_on   = (act_window != WWDT_CODE_OFF);
   assign count_p1 = count_reg + 14'h0001;

   // Expiry of the open (or Normal) period; closed-window restart
   assign expire = wdt_on & ~debug_halt & sif.tick_en & ~closed_reg &
                   ~sif.wdr_done &
                   (count_p1 >= wwdt_len(act_period));
   assign early  = wdt_on & ~debug_halt & sif.wdr_done & win_on &
                   armed_reg & closed_reg;

   // ==========================================================
   // Window counter and phase
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_reg  <= 14'h0000;
         closed_reg <= 1'b0;
         armed_reg  <= 1'b0;
      end else if (debug_halt || !wdt_on) begin
         count_reg  <= 14'h0000;
         closed_reg <= 1'b0;
         armed_reg  <= 1'b0;
      end else if (sif.wdr_done) begin
         count_reg  <= 14'h0000;
         closed_reg <= win_on;
         armed_reg  <= win_on;
      end else if (sif.ctrl_done && (!win_on ||
                   ctrl_reg[WWDT_WINDOW_LSB +: 4] == WWDT_CODE_OFF)) begin
         closed_reg <= 1'b0;
         armed_reg  <= 1'b0;
      end else if (sif.tick_en) begin
         if (closed_reg &&
             count_p1 >= wwdt_len(act_window)) begin
            closed_reg <= 1'b0;
            count_reg  <= 14'h0000;
         end else if (expire) begin
            count_reg <= 14'h0000;
         end else begin
            count_reg <= count_p1;
         end
      end
   end

   // Reset request held until acknowledged; a new event wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rst_req_reg <= 1'b0;
      end else if (expire || early) begin
         rst_req_reg <= 1'b1;
      end else if (sys_reset_ack) begin
         rst_req_reg <= 1'b0;
      end
   end
   assign sys_reset_req = rst_req_reg;
endmodule

// ===== tb/wwdt_top_assertions.sv
// Checker of bus handshakes and reset request at the watchdog pins
`timescale 1ns/1ps
module wwdt_top_chk
   import wwdt_pkg::*;
(
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Bus handshakes
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [3:0]  s_axi_araddr,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   // Debug and reset controller
   input wire logic        debug_halt,
   input wire logic        sys_reset_req,
   input wire logic        sys_reset_ack
);
   // ==========================================================
   // Bus answers
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write unanswered");
   b_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response not released");
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read unanswered");
   rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   r_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read data not released");
   dec_err_a: assert property (s_axi_arvalid && s_axi_arready
      && s_axi_araddr == 4'hc |=> s_axi_rresp == WWDT_RESP_DEC
      && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
   ok_resp_a: assert property (s_axi_arvalid && s_axi_arready
      && s_axi_araddr == 4'h0 |=> s_axi_rresp == WWDT_RESP_OKAY)
      else $error("control read refused");
   // ==========================================================
   // Reset request
   req_hold_a: assert property (sys_reset_req && !sys_reset_ack
      |=> sys_reset_req) else $error("reset request dropped early");
   req_clear_a: assert property (sys_reset_req && sys_reset_ack
      |-> ##[1:2] !sys_reset_req) else $error("reset request not cleared");
   halt_quiet_a: assert property (debug_halt [*3] |->
      !$rose(sys_reset_req)) else $error("reset request while halted");
endmodule

bind wwdt_top wwdt_top_chk u_wwdt_top_chk (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .debug_halt(debug_halt),
   .sys_reset_req(sys_reset_req), .sys_reset_ack(sys_reset_ack));

// ===== tb/wwdt_rst_model.sv
// Reset controller model that acknowledges watchdog reset requests
`timescale 1ns/1ps
module wwdt_rst_model #(
   parameter int ACK_DLY = 3   // Cycles before acknowledge
)(
   // Clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // Request and acknowledge
   input  wire logic sys_reset_req,
   output logic      sys_reset_ack,
   // Requests acknowledged so far
   output int        req_cnt
);
   int wait_cnt;
   // Acknowledge after a delay, release once the request drops
   always @(posedge aclk) begin
      if (!aresetn) begin
         sys_reset_ack <= 1'b0;
         wait_cnt      <= 0;
      end else if (sys_reset_ack) begin
         sys_reset_ack <= sys_reset_req;
      end else if (sys_reset_req) begin
         wait_cnt <= wait_cnt + 1;
         if (wait_cnt == ACK_DLY) begin
            sys_reset_ack <= 1'b1;
            req_cnt       <= req_cnt + 1;
            wait_cnt      <= 0;
         end
      end
   end
endmodule

// ===== tb/wwdt_tb_top.sv
// Self-checking bench of the windowed watchdog timer
`timescale 1ns/1ps
module wwdt_tb_top
   import wwdt_pkg::*;
;
   // ==========================================================
   // Signals
   localparam logic [7:0] KEY = 8'h3c;   // Arbitrary key
   logic        aclk, aresetn, tick, restart, halt, dbg, ack, req;
   logic        s_axi_awvalid, s_axi_wvalid, s_axi_arvalid;
   logic        s_axi_awready, s_axi_wready, s_axi_arready;
   logic        s_axi_bvalid, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rr, br;
   logic [3:0]  s_axi_awaddr, s_axi_araddr, strb;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [7:0]  fuse;
   int          req_cnt, n_errors, samples_checked, cyc, tdiv;

   wwdt_top #(.UNLOCK_KEY(KEY)) u_wwdt_top (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(strb),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1),
      .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arprot(3'h0), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'b1),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .watchdog_restart_instr(restart), .debug_halt(halt),
      .debug_mode(dbg), .watchdog_fuse_config(fuse),
      .watchdog_tick_clock(tick), .sys_reset_req(req), .sys_reset_ack(ack));
   wwdt_rst_model u_wwdt_rst_model (.aclk(aclk), .aresetn(aresetn),
      .sys_reset_req(req), .sys_reset_ack(ack), .req_cnt(req_cnt));

   // ==========================================================
   // Clock, tick of 16 clocks, run limit
   always #4 aclk = ~aclk;
   always @(posedge aclk) begin
      tdiv <= tdiv + 1;
      if (tdiv % 8 == 7) tick <= ~tick;
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_errors++;
         conclude();
      end
   end

   // ==========================================================
   // Helpers
   task automatic conclude();
      if (n_errors == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      samples_checked++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      logic ta, tw, tb;
      tb = 1'b0;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      while (!tb) begin
         @(negedge aclk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tb = s_axi_bvalid;
         br = s_axi_bresp;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
      end
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      logic ta, tr;
      tr = 1'b0;
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      while (!tr) begin
         @(negedge aclk);
         ta = s_axi_arvalid && s_axi_arready;
         tr = s_axi_rvalid;
         d  = s_axi_rdata;
         rr = s_axi_rresp;
         @(posedge aclk);
         if (ta) s_axi_arvalid <= 1'b0;
      end
   endtask
   task automatic ticks(input int n);
      repeat (n * 16) @(posedge aclk);
   endtask
   task automatic kick();
      restart <= 1'b1;
      @(posedge aclk);
      restart <= 1'b0;
   endtask
   // Key then control write, wait out the sync pending flag
   task automatic set_ctrl(input logic [7:0] d);
      logic [31:0] v;
      int          n;
      wr(4'h8, KEY);
      wr(4'h0, d);
      rd(4'h4, v);
      chk("sync_pending_flag", 32'h1, v & 32'h1);
      for (n = 0; n < 200 && v[0] === 1'b1; n++) begin
         rd(4'h4, v);
      end
      rd(4'h0, v);
      chk("primary_control", {24'h0, d}, v);
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_regs();
      logic [31:0] v;
      rd(4'h0, v);
      chk("control_after_reset", 32'h0, v);
      rd(4'hc, v);
      chk("unmapped_resp", {30'h0, WWDT_RESP_DEC}, {30'h0, rr});
      wr(4'h0, 8'h01);
      ticks(4);
      rd(4'h0, v);
      chk("control_without_key", 32'h0, v);
      wr(4'hc, 8'h00);
      chk("unmapped_wr_resp", {30'h0, WWDT_RESP_DEC}, {30'h0, br});
      wr(4'h8, KEY);
      strb <= 4'h0;
      wr(4'h0, 8'h01);
      strb <= 4'h1;
      ticks(4);
      rd(4'h0, v);
      chk("control_no_strobe", 32'h0, v);
   endtask
   task automatic t_normal();
      int c;
      set_ctrl(8'h01);
      c = req_cnt;
      repeat (6) begin
         ticks(3);
         kick();
      end
      chk("req_while_kicked", c, req_cnt);
      ticks(7);
      chk("req_before_expiry", c, req_cnt);
      ticks(5);
      chk("req_on_expiry", c + 1, req_cnt);
      set_ctrl(8'h00);
   endtask
   task automatic t_window();
      int c;
      set_ctrl(8'h11);
      c = req_cnt;
      kick();
      ticks(12);
      chk("first_kick_free", c, req_cnt);
      kick();
      ticks(4);
      chk("open_kick", c, req_cnt);
      kick();
      ticks(5);
      chk("closed_kick", c + 1, req_cnt);
      set_ctrl(8'h00);
   endtask
   task automatic t_lock();
      logic [31:0] v;
      wr(4'h8, KEY);
      wr(4'h4, 8'h80);
      rd(4'h4, v);
      chk("lock_set", 32'h80, v);
      wr(4'h8, KEY);
      wr(4'h0, 8'h05);
      ticks(4);
      rd(4'h0, v);
      chk("control_locked", 32'h0, v);
      wr(4'h8, KEY);
      wr(4'h4, 8'h00);
      rd(4'h4, v);
      chk("lock_kept", 32'h80, v);
      dbg <= 1'b1;
      wr(4'h8, KEY);
      wr(4'h4, 8'h00);
      rd(4'h4, v);
      chk("lock_cleared", 32'h0, v);
      dbg <= 1'b0;
   endtask
   // Reset in mid-run with a nonzero fuse, halted at first
   task automatic t_fuse();
      logic [31:0] v;
      int          c;
      fuse    <= 8'h21;
      aresetn <= 1'b0;
      halt    <= 1'b1;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      c = req_cnt;
      rd(4'h0, v);
      chk("control_from_fuse", 32'h21, v);
      rd(4'h4, v);
      chk("lock_from_fuse", 32'h80, v);
      ticks(12);
      chk("req_while_halted", c, req_cnt);
      halt <= 1'b0;
      ticks(6);
      chk("req_early_after_halt", c, req_cnt);
      ticks(5);
      chk("req_normal_after_halt", c + 1, req_cnt);
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      aclk          = 1'b0;
      aresetn       = 1'b0;
      tick          = 1'b0;
      restart       = 1'b0;
      halt          = 1'b0;
      dbg           = 1'b0;
      fuse          = 8'h00;
      s_axi_awvalid = 1'b0;
      s_axi_wvalid  = 1'b0;
      s_axi_arvalid = 1'b0;
      s_axi_awaddr  = 4'h0;
      s_axi_araddr  = 4'h0;
      s_axi_wdata   = 32'h0;
      strb          = 4'h1;
      rr            = 2'h0;
      n_errors      = 0;
      samples_checked = 0;
      cyc           = 0;
      tdiv          = 0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      t_regs();
      t_normal();
      t_window();
      t_lock();
      t_fuse();
      conclude();
   end
endmodule
